// *** rail_strobe_assignment_regs.sv ***
`timescale 1ns/1ps
`include "rsa_consts.svh"

module rail_strobe_assignment_regs (
	input  wire logic                  clock,
	input  wire logic                  reset_n,
	input  rsa_pkg::rsa_reg_req_s      regReq,
	input  wire logic                  writeUnlocked,
	output logic                 [7:0] regRdata,
	output logic                       writeRefused,
	input  wire logic                  freshnessSealFlag,
	input  rsa_pkg::rsa_seq_cmd_s      seqCmd,
	input  rsa_pkg::rsa_strobe_s       strobeEv,
	output logic                       strobeTaken,
	output logic                       strobeSkipped,
	output logic                 [5:0] railEnable,
	output rsa_pkg::rsa_seq_e          seqState
);
	import rsa_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic regHit(input logic [7:0] addr,
			input logic [7:0] offset);
		regHit = (addr == offset);
	endfunction

	function automatic logic sealedStrobe(input logic [3:0] index);
		sealedStrobe = (index == `RSA_STROBE_FIRST) ||
			(index == `RSA_STROBE_SECOND);
	endfunction

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [7:0] backup_q;
	logic [7:0] backup_d;
	logic [7:0] swLdo_q;
	logic [7:0] swLdo_d;
	logic [7:0] gpo_q;
	logic [7:0] gpo_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       refused_q;
	logic       refused_d;
	logic       writeOk;

	assign writeOk = regReq.write && writeUnlocked;

	always_comb begin
		backup_d = backup_q;
		swLdo_d = swLdo_q;
		gpo_d = gpo_q;
		refused_d = regReq.write && !writeUnlocked;
		if (writeOk) begin
			if (regHit(regReq.addr, `RSA_OFF_BACKUP)) begin
				// Reserved bits never store
				backup_d = regReq.wdata & `RSA_BACKUP_WMASK;
			end
			if (regHit(regReq.addr, `RSA_OFF_SWLDO)) begin
				swLdo_d = regReq.wdata;
			end
			if (regHit(regReq.addr, `RSA_OFF_GPO)) begin
				gpo_d = regReq.wdata;
			end
		end
		// Unmapped reads answer zero
		rdata_d = 8'h00;
		if (regHit(regReq.addr, `RSA_OFF_BACKUP)) begin
			rdata_d = backup_q;
		end else if (regHit(regReq.addr, `RSA_OFF_SWLDO)) begin
			rdata_d = swLdo_q;
		end else if (regHit(regReq.addr, `RSA_OFF_GPO)) begin
			rdata_d = gpo_q;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			backup_q <= `RSA_RST_BACKUP;
			swLdo_q <= `RSA_RST_SWLDO;
			gpo_q <= `RSA_RST_GPO;
			rdata_q <= 8'h00;
			refused_q <= 1'b0;
		end else begin
			backup_q <= backup_d;
			swLdo_q <= swLdo_d;
			gpo_q <= gpo_d;
			rdata_q <= rdata_d;
			refused_q <= refused_d;
		end
	end

	assign regRdata = rdata_q;
	assign writeRefused = refused_q;

	// ****************************************************************
	// Field decode per rail
	// ****************************************************************
	// Rail order: backup one, backup two, load switch, regulator,
	// first output, second output
	logic     [3:0] railCode [`RSA_NUM_RAILS];
	rsa_hit_t       railHit [`RSA_NUM_RAILS];

	assign railCode[0] = {2'b00, backup_q[`RSA_BK1_LSB +: 2]};
	assign railCode[1] = {2'b00, backup_q[`RSA_BK2_LSB +: 2]};
	assign railCode[2] = swLdo_q[`RSA_HI_LSB +: 4];
	assign railCode[3] = swLdo_q[`RSA_LO_LSB +: 4];
	assign railCode[4] = gpo_q[`RSA_LO_LSB +: 4];
	assign railCode[5] = gpo_q[`RSA_HI_LSB +: 4];

	genvar r;
	generate
		for (r = 0; r < `RSA_NUM_RAILS; r++) begin : g_rail
			rsa_strobe_decode #(
				.WIDE (r >= 2)
			) u_decode (
				.code      (railCode[r]),
				.strobeHit (railHit[r])
			);
		end
	endgenerate

	// ****************************************************************
	// Sequence phase
	// ****************************************************************
	rsa_seq_e state_q;
	rsa_seq_e state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			RSA_IDLE: begin
				if (seqCmd.startUp) begin
					state_d = RSA_UP;
				end else if (seqCmd.startDown) begin
					state_d = RSA_DOWN;
				end
			end
			RSA_UP, RSA_DOWN: begin
				if (seqCmd.finish) begin
					state_d = RSA_IDLE;
				end
			end
			default: begin
				state_d = RSA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= RSA_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign seqState = state_q;

	// ****************************************************************
	// Strobe execution
	// ****************************************************************
	// A strobe only counts in the phase whose direction it carries
	logic       phaseOk;
	logic       indexOk;
	logic [5:0] en_q;
	logic [5:0] en_d;

	assign phaseOk = strobeEv.down ? (state_q == RSA_DOWN) :
		(state_q == RSA_UP);
	assign indexOk = strobeEv.index >= `RSA_STROBE_FIRST &&
		strobeEv.index <= `RSA_WIDE_LAST;
	assign strobeSkipped = strobeEv.valid && phaseOk &&
		sealedStrobe(strobeEv.index) && freshnessSealFlag;
	assign strobeTaken = strobeEv.valid && phaseOk && indexOk &&
		!strobeSkipped;

	always_comb begin
		en_d = en_q;
		for (int i = 0; i < `RSA_NUM_RAILS; i++) begin
			if (strobeTaken && railHit[i][strobeEv.index - 4'h1]) begin
				en_d[i] = !strobeEv.down;
			end
		end
		// Backup rails hold once the seal is broken
		if (freshnessSealFlag && strobeEv.down) begin
			en_d[1:0] = en_q[1:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 6'h00;
		end else begin
			en_q <= en_d;
		end
	end

	assign railEnable = en_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	reserved_zero_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		$past(regReq.addr) == `RSA_OFF_BACKUP |->
			regRdata[7:6] == 2'b00 && regRdata[3:2] == 2'b00)
		else $error("backup reserved bits not zero");

	backup_up_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		strobeTaken && !strobeEv.down &&
			(backup_q[1:0] == 2'h1 || backup_q[1:0] == 2'h2) &&
			strobeEv.index == {2'b00, backup_q[1:0]} |=> railEnable[0])
		else $error("backup rail one not enabled at its strobe");

	backup_two_up_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		strobeTaken && !strobeEv.down &&
			(backup_q[5:4] == 2'h1 || backup_q[5:4] == 2'h2) &&
			strobeEv.index == {2'b00, backup_q[5:4]} |=> railEnable[1])
		else $error("backup rail two not enabled at its strobe");

	backup_unused_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(backup_q[5:4] == 2'h0 || backup_q[5:4] == 2'h3) &&
			!freshnessSealFlag |=> $stable(railEnable[1]))
		else $error("unsequenced backup rail changed");

	seal_skip_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		strobeEv.valid && freshnessSealFlag &&
			sealedStrobe(strobeEv.index) |-> !strobeTaken)
		else $error("sealed strobe executed");

	seal_hold_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		freshnessSealFlag && railEnable[0] && state_q == RSA_DOWN
			|=> railEnable[0])
		else $error("backup rail turned off after seal broken");

	wide_up_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		strobeTaken && !strobeEv.down && swLdo_q[7:4] >= 4'h3 &&
			swLdo_q[7:4] <= 4'hA && strobeEv.index == swLdo_q[7:4]
			|=> railEnable[2])
		else $error("load switch not enabled at its strobe");

	gpo_up_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		strobeTaken && !strobeEv.down && gpo_q[3:0] >= 4'h3 &&
			gpo_q[3:0] <= 4'hA && strobeEv.index == gpo_q[3:0]
			|=> railEnable[4])
		else $error("first output not enabled at its strobe");

	wide_down_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		strobeTaken && strobeEv.down && swLdo_q[3:0] >= 4'h3 &&
			swLdo_q[3:0] <= 4'hA && strobeEv.index == swLdo_q[3:0]
			|=> !railEnable[3])
		else $error("regulator not disabled at its strobe");

	wide_unused_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(swLdo_q[3:0] < 4'h3 || swLdo_q[3:0] > 4'hA) |=>
			$stable(railEnable[3]))
		else $error("unsequenced regulator changed");

	swldo_write_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		writeOk && regReq.addr == `RSA_OFF_SWLDO |=>
			swLdo_q == $past(regReq.wdata) ##1
			($past(regReq.addr) != `RSA_OFF_SWLDO ||
			regRdata == $past(swLdo_q)))
		else $error("switch and regulator register write lost");

	gpo_write_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		writeOk && regReq.addr == `RSA_OFF_GPO |=>
			gpo_q == $past(regReq.wdata))
		else $error("output register write lost");

	backup_write_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		writeOk && regReq.addr == `RSA_OFF_BACKUP |=>
			backup_q == ($past(regReq.wdata) & `RSA_BACKUP_WMASK))
		else $error("backup register write wrong");

	locked_write_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		regReq.write && !writeUnlocked |=>
			writeRefused && $stable(backup_q) && $stable(swLdo_q) &&
			$stable(gpo_q))
		else $error("locked write changed a register");

endmodule

// *** rsa_consts.svh ***
`ifndef RSA_CONSTS_SVH
`define RSA_CONSTS_SVH

// ****************************************************************
// Register subaddresses
// ****************************************************************
`define RSA_OFF_BACKUP 8'h24
`define RSA_OFF_SWLDO 8'h25
`define RSA_OFF_GPO 8'h26

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define RSA_RST_BACKUP 8'h12
`define RSA_RST_SWLDO 8'h63
`define RSA_RST_GPO 8'h03
`define RSA_BACKUP_WMASK 8'h33

// ****************************************************************
// Field positions
// ****************************************************************
`define RSA_BK1_LSB 0
`define RSA_BK2_LSB 4
`define RSA_LO_LSB 0
`define RSA_HI_LSB 4

// ****************************************************************
// Strobe codes
// ****************************************************************
`define RSA_NUM_RAILS 6
`define RSA_STROBE_FIRST 4'h1
`define RSA_STROBE_SECOND 4'h2
`define RSA_WIDE_FIRST 4'h3
`define RSA_WIDE_LAST 4'hA

`endif

// *** rsa_pkg.sv ***
package rsa_pkg;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsa_reg_req_s;

	typedef struct packed {
		logic       valid;
		logic       down;
		logic [3:0] index;
	} rsa_strobe_s;

	typedef struct packed {
		logic startUp;
		logic startDown;
		logic finish;
	} rsa_seq_cmd_s;

	// ****************************************************************
	// Sequence state and strobe hit vector
	// ****************************************************************
	typedef enum logic [2:0] {
		RSA_IDLE = 3'b001,
		RSA_UP   = 3'b010,
		RSA_DOWN = 3'b100
	} rsa_seq_e;

	// Bit n stands for strobe n+1
	typedef logic [9:0] rsa_hit_t;

endpackage

// *** rsa_rail_model.sv ***
`timescale 1ns/1ps
module rsa_rail_model (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [5:0] railEnable,
	output logic      [5:0] railOn
);
	logic [5:0] railOn_d;
	logic [5:0] railOn_q;
	// ****************************************************************
	// Rails
	// ****************************************************************
	// One cycle ramp, so a glitch on an enable shows on the rail
	always_comb begin
		railOn_d = railEnable;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			railOn_q <= 6'h00;
		end else begin
			railOn_q <= railOn_d;
		end
	end
	assign railOn = railOn_q;
endmodule

// *** rsa_strobe_decode.sv ***
`timescale 1ns/1ps
`include "rsa_consts.svh"

module rsa_strobe_decode #(
	parameter bit WIDE = 1'b1
) (
	input  wire logic       [3:0] code,
	output rsa_pkg::rsa_hit_t     strobeHit
);
	import rsa_pkg::*;

	always_comb begin
		strobeHit = '0;
		if (WIDE) begin
			if (code >= `RSA_WIDE_FIRST && code <= `RSA_WIDE_LAST) begin
				strobeHit[code - 4'h1] = 1'b1;
			end
		end else begin
			if (code == `RSA_STROBE_FIRST || code == `RSA_STROBE_SECOND) begin
				strobeHit[code - 4'h1] = 1'b1;
			end
		end
		// Other codes leave the hit vector empty
	end

endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
	import rsa_pkg::*;
	logic         clock;
	logic         reset_n;
	logic         writeUnlocked;
	logic         freshnessSealFlag;
	rsa_reg_req_s regReq;
	rsa_seq_cmd_s seqCmd;
	rsa_strobe_s  strobeEv;
	logic [7:0]   regRdata;
	logic         writeRefused;
	logic         strobeTaken;
	logic         strobeSkipped;
	logic [5:0]   railEnable;
	logic [5:0]   railOn;
	rsa_seq_e     seqState;
	logic [1:0]   acks;
	int           failCount;
	int           checksDone;
	// ****************************************************************
	// Harness
	// ****************************************************************
	rail_strobe_assignment_regs rail_strobe_assignment_regs_i (
		.clock(clock), .reset_n(reset_n), .regReq(regReq),
		.writeUnlocked(writeUnlocked), .regRdata(regRdata),
		.writeRefused(writeRefused), .freshnessSealFlag(freshnessSealFlag),
		.seqCmd(seqCmd), .strobeEv(strobeEv), .strobeTaken(strobeTaken),
		.strobeSkipped(strobeSkipped), .railEnable(railEnable),
		.seqState(seqState));
	rsa_rail_model rsa_rail_model_i (
		.clock(clock), .reset_n(reset_n), .railEnable(railEnable),
		.railOn(railOn));
	initial clock = 1'b0;
	always #2 clock = ~clock;
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED at %0t: saw %h expected %h",
				$time, seen, exp);
		end
	endtask
	task completeRun;
		if (failCount == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task doReset;
		@(posedge clock);
		reset_n <= 1'b0;
		freshnessSealFlag <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
	endtask
	// Host side unlocks per write, as the password unit demands
	task wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
		@(posedge clock);
		regReq <= '{1'b1, a, d};
		writeUnlocked <= unl;
		@(posedge clock);
		regReq.write <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		regReq.addr <= a;
		repeat (2) @(posedge clock);
		#1 v = regRdata;
	endtask
	task cmd(input rsa_seq_cmd_s c);
		@(posedge clock);
		seqCmd <= c;
		@(posedge clock);
		seqCmd <= '0;
	endtask
	// Acks are combinational, so they are caught before the taking edge
	task strobe(input logic down, input logic [3:0] idx);
		@(posedge clock);
		strobeEv <= '{1'b1, down, idx};
		#1 acks = {strobeTaken, strobeSkipped};
		@(posedge clock);
		strobeEv.valid <= 1'b0;
		#1;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task scenRegs;
		logic [7:0] v;
		doReset();
		rd(8'h24, v);
		check(v, 8'h12);
		rd(8'h25, v);
		check(v, 8'h63);
		rd(8'h26, v);
		check(v, 8'h03);
		rd(8'h30, v);
		check(v, 8'h00);
		wr(8'h25, 8'hA5, 1'b0);
		check({7'h00, writeRefused}, 8'h01);
		rd(8'h25, v);
		check(v, 8'h63);
		wr(8'h24, 8'hFF, 1'b1);
		check({7'h00, writeRefused}, 8'h00);
		rd(8'h24, v);
		check(v, 8'h33);
		wr(8'h25, 8'h5A, 1'b1);
		wr(8'h26, 8'hA5, 1'b1);
		rd(8'h25, v);
		check(v, 8'h5A);
		rd(8'h26, v);
		check(v, 8'hA5);
	endtask
	// Every regulator code against every wide strobe, in order
	task scenWide;
		logic [7:0] want;
		for (int c = 0; c < 16; c++) begin
			doReset();
			wr(8'h25, {4'h0, c[3:0]}, 1'b1);
			cmd(3'b100);
			for (int s = 3; s <= 10; s++) begin
				strobe(1'b0, s[3:0]);
				want = {7'h00, c >= 3 && c <= 10 && s >= c};
				check({7'h00, railEnable[3]}, want);
			end
			check({7'h00, railEnable[2]}, 8'h00);
			cmd(3'b001);
		end
	endtask
	task scenBackup;
		logic [7:0] want;
		for (int c = 0; c < 4; c++) begin
			doReset();
			wr(8'h24, {2'b00, c[1:0], 2'b00, c[1:0]}, 1'b1);
			cmd(3'b100);
			strobe(1'b0, 4'h1);
			want = (c == 1) ? 8'h03 : 8'h00;
			check({6'h00, railEnable[1:0]}, want);
			strobe(1'b0, 4'h2);
			want = (c == 1 || c == 2) ? 8'h03 : 8'h00;
			check({6'h00, railEnable[1:0]}, want);
			@(posedge clock);
			#1 check({6'h00, railOn[1:0]}, want);
			cmd(3'b001);
		end
	endtask
	// Seal intact: full ramp up, refused strobes, full ramp down
	task scenUpDown;
		doReset();
		wr(8'h26, 8'hA4, 1'b1);
		cmd(3'b100);
		#1 check({5'h00, seqState}, 8'h02);
		for (int s = 1; s <= 10; s++) begin
			strobe(1'b0, s[3:0]);
		end
		check({2'h0, railEnable}, 8'h3F);
		strobe(1'b0, 4'h0);
		check({6'h00, acks}, 8'h00);
		cmd(3'b001);
		cmd(3'b010);
		#1 check({5'h00, seqState}, 8'h04);
		strobe(1'b0, 4'h3);
		check({6'h00, acks}, 8'h00);
		strobe(1'b1, 4'hA);
		check({2'h0, railEnable}, 8'h1F);
		for (int s = 9; s >= 1; s--) begin
			strobe(1'b1, s[3:0]);
		end
		check({2'h0, railEnable}, 8'h00);
		cmd(3'b001);
	endtask
	task scenSeal;
		doReset();
		@(posedge clock);
		freshnessSealFlag <= 1'b1;
		cmd(3'b100);
		strobe(1'b0, 4'h1);
		check({6'h00, acks}, 8'h01);
		strobe(1'b0, 4'h2);
		check({6'h00, railEnable[1:0]}, 8'h00);
		strobe(1'b0, 4'h3);
		check({6'h00, acks}, 8'h02);
		check({7'h00, railEnable[3]}, 8'h01);
		cmd(3'b001);
	endtask
	// Seal broken after power-up: down strobes must spare backup rails
	task scenSealDown;
		doReset();
		cmd(3'b100);
		strobe(1'b0, 4'h1);
		strobe(1'b0, 4'h2);
		strobe(1'b0, 4'h3);
		check({6'h00, railEnable[1:0]}, 8'h03);
		cmd(3'b001);
		freshnessSealFlag <= 1'b1;
		cmd(3'b010);
		strobe(1'b1, 4'h3);
		check({7'h00, railEnable[3]}, 8'h00);
		strobe(1'b1, 4'h2);
		strobe(1'b1, 4'h1);
		check({6'h00, acks}, 8'h01);
		check({6'h00, railEnable[1:0]}, 8'h03);
		cmd(3'b001);
	endtask
	// ****************************************************************
	// Main
	// ****************************************************************
	initial begin
		reset_n = 1'b0;
		regReq = '0;
		seqCmd = '0;
		strobeEv = '0;
		writeUnlocked = 1'b0;
		freshnessSealFlag = 1'b0;
		acks = 2'b00;
		failCount = 0;
		checksDone = 0;
		scenRegs();
		scenWide();
		scenBackup();
		scenSeal();
		scenUpDown();
		scenSealDown();
		completeRun();
	end
	// Hang guard, far above the longest legal run
	initial begin
		repeat (20000) @(posedge clock);
		failCount++;
		completeRun();
	end
endmodule
